// ==== verilog/psr_pkg.sv ====
// constants and types for the power, sleep and reset controller
package psr_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
  localparam logic [7:0] IDX_MODULE_CLOCK_GATE = 8'hEA;
  localparam logic [7:0] IDX_WAKE_SOURCE_ENABLE = 8'hEB;
  localparam logic [7:0] IDX_PERSISTENT_SCRATCH = 8'hFE;
  localparam logic [7:0] IDX_WATCHDOG_COUNTER = 8'hFF;
  localparam logic [7:0] IDX_UNLOCK_KEY = 8'hA1;
  localparam logic [7:0] IDX_GLOBAL_CONFIG = 8'hB1;
  localparam logic [7:0] IDX_WATCHDOG_STATUS = 8'hB2;
  localparam int ADDR_W = 12;
  // reset values and the last watchdog count
  localparam logic [7:0] POWER_CONTROL_RST = 8'h10;
  localparam logic [7:0] CLOCK_GATE_RST = 8'h00;
  localparam logic [7:0] WAKE_ENABLE_RST = 8'h00;
  localparam logic [7:0] SCRATCH_RST = 8'h00;
  localparam logic [7:0] WATCHDOG_RST = 8'h00;
  localparam logic [7:0] WATCHDOG_LAST = 8'hFF;
  // power control fields
  localparam int PC_BAUD = 7;
  localparam int PC_CAUSE_HI = 5;
  localparam int PC_CAUSE_LO = 4;
  localparam int PC_GF1 = 3;
  localparam int PC_GF0 = 2;
  localparam int PC_PD = 1;
  // global config fields
  localparam int GC_BOOT = 5;
  localparam int GC_SWRST = 4;
  localparam int GC_WDOG_EN = 0;
  localparam logic [1:0] GC_FIXED = 2'h3;
  // clock gate bit that software may not change
  localparam int CG_PWM_SPI2 = 4;
  // reset cause codes
  localparam logic [1:0] CAUSE_SW = 2'h0;
  localparam logic [1:0] CAUSE_POR = 2'h1;
  localparam logic [1:0] CAUSE_WDOG = 2'h2;
  localparam logic [1:0] CAUSE_EXT = 2'h3;
  // unlock keys and window, external reset hold, watchdog divide and response codes
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [4:0] WINDOW_CYCLES = 5'h10;
  localparam logic [4:0] EXT_HOLD_CYCLES = 5'h10;
  localparam int WDOG_DIVIDE = 262144;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    UNLOCK_IDLE = 2'b00,
    UNLOCK_KEY1 = 2'b01,
    UNLOCK_OPEN = 2'b11
  } unlock_state_type;

  typedef struct packed {
    logic usb_event;
    logic serial2_rx_primary;
    logic serial2_rx_alternate;
    logic rs485_rx;
    logic port1_pin5;
    logic port1_pin4;
    logic port0_pin3;
    logic timer3_cap_primary;
    logic timer3_cap_alternate;
    logic port3_pin2;
    logic port3_pin3;
    logic serial1_rx_primary;
    logic serial1_rx_alternate;
  } wake_pins_type;

  typedef struct packed {
    logic serial2_pin_mode_select;
    logic rs485_mode;
    logic timer3_capture_mode;
    logic timer3_pin_select;
    logic serial1_pin_select;
  } pin_modes_type;
endpackage

// ==== verilog/power_sleep_reset_control.sv ====
// power, sleep, wake-up, watchdog and reset-cause control behind an AXI4-Lite slave
//
// Local design decision: the AXI4-Lite slave port.
module power_sleep_reset_control #(
  parameter int WDOG_DIVIDE = psr_pkg::WDOG_DIVIDE
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [psr_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [psr_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire psr_pkg::wake_pins_type wake_pins_in,
  input wire psr_pkg::pin_modes_type pin_modes_in,
  input wire logic reset_pin_in,
  input wire logic reset_pin_function_enable_in,
  output logic [7:0] clock_gate_out,
  output logic sleep_out,
  output logic serial1_baud_double_out,
  output logic watchdog_overflow_flag_out,
  output logic hot_reset_out
);
  localparam int PRE_W = $clog2(WDOG_DIVIDE);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(WDOG_DIVIDE - 1);

  function automatic logic [7:0] reg_index(input logic [psr_pkg::ADDR_W-1:0] addr);
    reg_index = addr[9:2];
  endfunction

  function automatic logic is_mapped(input logic [psr_pkg::ADDR_W-1:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    is_mapped = (addr[psr_pkg::ADDR_W-1:10] == '0) &&
      (idx == psr_pkg::IDX_POWER_CONTROL || idx == psr_pkg::IDX_MODULE_CLOCK_GATE ||
       idx == psr_pkg::IDX_WAKE_SOURCE_ENABLE || idx == psr_pkg::IDX_PERSISTENT_SCRATCH ||
       idx == psr_pkg::IDX_WATCHDOG_COUNTER || idx == psr_pkg::IDX_UNLOCK_KEY ||
       idx == psr_pkg::IDX_GLOBAL_CONFIG || idx == psr_pkg::IDX_WATCHDOG_STATUS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write and read channels
  logic aw_got_q;
  logic w_got_q;
  logic [psr_pkg::ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_lane0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [7:0] rdata_q;

  wire wr_fire = aw_got_q && w_got_q && !bvalid_q;
  wire wr_ok = wr_fire && is_mapped(aw_addr_q) && w_lane0_q;
  wire [7:0] wr_idx = reg_index(aw_addr_q);
  wire ar_fire = s_axi_arvalid_in && !rvalid_q;
  wire [7:0] rd_idx = reg_index(s_axi_araddr_in);

  assign s_axi_awready_out = !aw_got_q;
  assign s_axi_wready_out = !w_got_q;
  assign s_axi_arready_out = !rvalid_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rresp_out = rresp_q;
  assign s_axi_rdata_out = {24'h00_0000, rdata_q};

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 8'h00;
      w_lane0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= psr_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && !aw_got_q) begin
        aw_got_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr_in;
      end else if (wr_fire) begin
        aw_got_q <= 1'b0;
      end
      if (s_axi_wvalid_in && !w_got_q) begin
        w_got_q <= 1'b1;
        w_data_q <= s_axi_wdata_in[7:0];
        w_lane0_q <= s_axi_wstrb_in[0];
      end else if (wr_fire) begin
        w_got_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(aw_addr_q) ? psr_pkg::RESP_OKAY : psr_pkg::RESP_SLVERR;
      end else if (s_axi_bready_in) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // unlock window
  psr_pkg::unlock_state_type unlock_q;
  logic [4:0] win_cnt_q;
  wire key_wr = wr_ok && wr_idx == psr_pkg::IDX_UNLOCK_KEY;
  wire win_open = unlock_q == psr_pkg::UNLOCK_OPEN;
  wire prot_wr = wr_ok && win_open;
  wire win_end = win_cnt_q == psr_pkg::WINDOW_CYCLES - 5'h01;
  logic hot_rst;

  always_ff @(posedge clk_in) begin
    if (srst_in || hot_rst) begin
      unlock_q <= psr_pkg::UNLOCK_IDLE;
      win_cnt_q <= 5'h00;
    end else begin
      win_cnt_q <= win_open ? win_cnt_q + 5'h01 : 5'h00;
      case (unlock_q)
        psr_pkg::UNLOCK_IDLE: begin
          if (key_wr && w_data_q == psr_pkg::KEY_FIRST) unlock_q <= psr_pkg::UNLOCK_KEY1;
        end
        psr_pkg::UNLOCK_KEY1: begin
          if (key_wr) begin
            unlock_q <= (w_data_q == psr_pkg::KEY_SECOND) ?
              psr_pkg::UNLOCK_OPEN : psr_pkg::UNLOCK_IDLE;
          end
        end
        psr_pkg::UNLOCK_OPEN: begin
          if (key_wr || win_end) unlock_q <= psr_pkg::UNLOCK_IDLE;
        end
        default: unlock_q <= psr_pkg::UNLOCK_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake pin synchronizers and wake decode
  psr_pkg::wake_pins_type sync1_q;
  psr_pkg::wake_pins_type sync2_q;
  logic p32_prev_q;
  logic [7:0] wake_en_q;

  wire serial2_rx = pin_modes_in.rs485_mode ? sync2_q.rs485_rx :
    (pin_modes_in.serial2_pin_mode_select ? sync2_q.serial2_rx_primary :
     sync2_q.serial2_rx_alternate);
  wire timer3_cap = pin_modes_in.timer3_pin_select ? sync2_q.timer3_cap_alternate :
    sync2_q.timer3_cap_primary;
  wire serial1_rx = pin_modes_in.serial1_pin_select ? sync2_q.serial1_rx_alternate :
    sync2_q.serial1_rx_primary;
  wire [7:0] wake_cause = {
    sync2_q.usb_event,
    !serial2_rx,
    !sync2_q.port1_pin5,
    !sync2_q.port1_pin4,
    !sync2_q.port0_pin3,
    pin_modes_in.timer3_capture_mode && !timer3_cap,
    (sync2_q.port3_pin2 != p32_prev_q) || !sync2_q.port3_pin3,
    !serial1_rx
  };
  wire wake_hit = |(wake_cause & wake_en_q);

  always_ff @(posedge clk_in) begin
    sync1_q <= wake_pins_in;
    sync2_q <= sync1_q;
    p32_prev_q <= sync2_q.port3_pin2;
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  logic [PRE_W-1:0] pre_cnt_q;
  logic [7:0] wdog_q;
  logic wdog_flag_q;
  wire wdog_tick = pre_cnt_q == PRE_LAST;
  wire wdog_wr = wr_ok && wr_idx == psr_pkg::IDX_WATCHDOG_COUNTER;
  wire wdog_ovf = wdog_tick && wdog_q == psr_pkg::WATCHDOG_LAST && !wdog_wr;

  always_ff @(posedge clk_in) begin
    if (srst_in || hot_rst) begin
      pre_cnt_q <= '0;
      wdog_q <= psr_pkg::WATCHDOG_RST;
      wdog_flag_q <= 1'b0;
    end else begin
      pre_cnt_q <= wdog_tick ? '0 : pre_cnt_q + PRE_W'(1);
      if (wdog_wr) wdog_q <= w_data_q;
      else if (wdog_tick) wdog_q <= wdog_q + 8'h01;
      if (wdog_ovf) wdog_flag_q <= 1'b1;
      else if (wdog_wr) wdog_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset sources and cause
  logic [4:0] ext_cnt_q;
  logic wdog_en_q;
  logic boot_q;
  logic sw_req_q;
  logic [1:0] cause_q;
  logic hot_q;
  wire ext_high = reset_pin_in && reset_pin_function_enable_in;
  wire ext_rst = ext_high && ext_cnt_q == psr_pkg::EXT_HOLD_CYCLES - 5'h01;
  wire wdog_rst = wdog_ovf && wdog_en_q;
  wire sw_counts = !boot_q || wdog_en_q;
  assign hot_rst = ext_rst || wdog_rst || sw_req_q;
  wire [1:0] cause_d = ext_rst ? psr_pkg::CAUSE_EXT :
    wdog_rst ? psr_pkg::CAUSE_WDOG :
    sw_counts ? psr_pkg::CAUSE_SW : cause_q;
  wire gc_wr = prot_wr && wr_idx == psr_pkg::IDX_GLOBAL_CONFIG;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ext_cnt_q <= 5'h00;
      cause_q <= psr_pkg::CAUSE_POR;
      boot_q <= 1'b1;
      hot_q <= 1'b0;
    end else begin
      ext_cnt_q <= !ext_high ? 5'h00 :
        (ext_cnt_q == psr_pkg::EXT_HOLD_CYCLES ? ext_cnt_q : ext_cnt_q + 5'h01);
      if (hot_rst) cause_q <= cause_d;
      if (sw_req_q) boot_q <= 1'b0;
      hot_q <= hot_rst;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in || hot_rst) begin
      wdog_en_q <= 1'b0;
      sw_req_q <= 1'b0;
    end else if (gc_wr) begin
      wdog_en_q <= w_data_q[psr_pkg::GC_WDOG_EN];
      sw_req_q <= w_data_q[psr_pkg::GC_SWRST];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power control, clock gates, wake enables, scratch
  logic [7:0] gate_q;
  logic pd_q;
  logic baud_q;
  logic [1:0] gf_q;
  logic [7:0] scratch_q;
  wire pc_wr = wr_ok && wr_idx == psr_pkg::IDX_POWER_CONTROL;
  wire pd_wr = pc_wr && w_data_q[psr_pkg::PC_PD];

  always_ff @(posedge clk_in) begin
    if (srst_in || hot_rst) begin
      gate_q <= psr_pkg::CLOCK_GATE_RST;
      wake_en_q <= psr_pkg::WAKE_ENABLE_RST;
      pd_q <= psr_pkg::POWER_CONTROL_RST[psr_pkg::PC_PD];
      baud_q <= psr_pkg::POWER_CONTROL_RST[psr_pkg::PC_BAUD];
      gf_q <= psr_pkg::POWER_CONTROL_RST[psr_pkg::PC_GF1:psr_pkg::PC_GF0];
    end else begin
      if (prot_wr && wr_idx == psr_pkg::IDX_MODULE_CLOCK_GATE) begin
        gate_q <= w_data_q & ~(8'h01 << psr_pkg::CG_PWM_SPI2);
      end
      if (prot_wr && wr_idx == psr_pkg::IDX_WAKE_SOURCE_ENABLE) wake_en_q <= w_data_q;
      if (pc_wr) begin
        baud_q <= w_data_q[psr_pkg::PC_BAUD];
        gf_q <= w_data_q[psr_pkg::PC_GF1:psr_pkg::PC_GF0];
      end
      if (pd_wr) pd_q <= 1'b1;
      else if (pd_q && wake_hit) pd_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) scratch_q <= psr_pkg::SCRATCH_RST;
    else if (wr_ok && wr_idx == psr_pkg::IDX_PERSISTENT_SCRATCH) scratch_q <= w_data_q;
  end

  assign clock_gate_out = gate_q;
  assign sleep_out = pd_q;
  assign serial1_baud_double_out = baud_q;
  assign watchdog_overflow_flag_out = wdog_flag_q;
  assign hot_reset_out = hot_q;

  ////////////////////////////////////////////////////////////////////////////
  // read data
  wire [7:0] pc_read = {baud_q, 1'b0, cause_q, gf_q, pd_q, 1'b0};
  wire [7:0] gc_read = {psr_pkg::GC_FIXED, boot_q, sw_req_q, 3'h0, wdog_en_q};
  wire [7:0] rd_mux =
    rd_idx == psr_pkg::IDX_POWER_CONTROL ? pc_read :
    rd_idx == psr_pkg::IDX_MODULE_CLOCK_GATE ? gate_q :
    rd_idx == psr_pkg::IDX_WAKE_SOURCE_ENABLE ? wake_en_q :
    rd_idx == psr_pkg::IDX_PERSISTENT_SCRATCH ? scratch_q :
    rd_idx == psr_pkg::IDX_WATCHDOG_COUNTER ? wdog_q :
    rd_idx == psr_pkg::IDX_GLOBAL_CONFIG ? gc_read :
    rd_idx == psr_pkg::IDX_WATCHDOG_STATUS ? {7'h00, wdog_flag_q} : 8'h00;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rvalid_q <= 1'b0;
      rresp_q <= psr_pkg::RESP_OKAY;
      rdata_q <= 8'h00;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rresp_q <= is_mapped(s_axi_araddr_in) ? psr_pkg::RESP_OKAY : psr_pkg::RESP_SLVERR;
      rdata_q <= rd_mux;
    end else if (s_axi_rready_in) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  chk_window_bound: assert property ($rose(win_open) |-> ##[1:23] !win_open)
    else $error("unlock window stayed open too long");
  chk_window_min: assert property ($fell(win_open) && !$past(hot_rst) |->
    $past(key_wr) || $past(win_cnt_q) >= 5'd12)
    else $error("unlock window closed too early");
  chk_protect_wake: assert property (wr_ok && wr_idx == psr_pkg::IDX_WAKE_SOURCE_ENABLE &&
    !win_open && !hot_rst |=> $stable(wake_en_q))
    else $error("wake enable changed while locked");
  chk_wdog_flag: assert property (wdog_ovf && !hot_rst |=> wdog_flag_q && wdog_q == 8'h00)
    else $error("watchdog rollover did not set flag");
  chk_wdog_rate: assert property (wdog_tick |=> !wdog_tick)
    else $error("watchdog ticks back to back");
  chk_scratch_keep: assert property (hot_rst && !(wr_ok &&
    wr_idx == psr_pkg::IDX_PERSISTENT_SCRATCH) |=> $stable(scratch_q))
    else $error("scratch changed by hot reset");
  chk_pd_wake: assert property (pd_q && wake_hit && !pd_wr && !hot_rst |=> !sleep_out)
    else $error("sleep not left on wake");
  chk_gate_fixed: assert property (!clock_gate_out[psr_pkg::CG_PWM_SPI2])
    else $error("read-only clock gate bit changed");
  chk_cause_wdog: assert property (wdog_rst && !ext_rst |=>
    cause_q == psr_pkg::CAUSE_WDOG && hot_reset_out)
    else $error("watchdog reset cause not recorded");
  chk_cause_keep: assert property (sw_req_q && boot_q && !wdog_en_q && !ext_rst |=>
    $stable(cause_q))
    else $error("software reset changed kept cause");
  chk_bresp_hold: assert property (bvalid_q && !s_axi_bready_in |=> bvalid_q && $stable(bresp_q))
    else $error("write response dropped");

  cov_unlock: cover property ($rose(win_open));
  cov_wake: cover property (pd_q ##1 !pd_q);
  cov_wdog_reset: cover property (wdog_rst);
endmodule

// ==== bench/wake_source_model.sv ====
// wake-up sources and port pins seen by the controller while asleep
module wake_source_model (
  input wire logic [3:0] fire_in,
  output psr_pkg::wake_pins_type wake_pins_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // fire_in 0 keeps every source idle, n+1 fires the source of wake bit n
  // codes 9 to d drive the edge pin and the alternate inputs
  always_comb begin
    wake_pins_out = '1;
    wake_pins_out.usb_event = 1'b0;
    case (fire_in)
      4'h8: wake_pins_out.usb_event = 1'b1;
      4'h7: wake_pins_out.serial2_rx_primary = 1'b0;
      4'h6: wake_pins_out.port1_pin5 = 1'b0;
      4'h5: wake_pins_out.port1_pin4 = 1'b0;
      4'h4: wake_pins_out.port0_pin3 = 1'b0;
      4'h3: wake_pins_out.timer3_cap_primary = 1'b0;
      4'h2: wake_pins_out.port3_pin3 = 1'b0;
      4'h1: wake_pins_out.serial1_rx_primary = 1'b0;
      4'h9: wake_pins_out.port3_pin2 = 1'b0;
      4'hA: wake_pins_out.rs485_rx = 1'b0;
      4'hB: wake_pins_out.serial1_rx_alternate = 1'b0;
      4'hC: wake_pins_out.timer3_cap_alternate = 1'b0;
      4'hD: wake_pins_out.serial2_rx_alternate = 1'b0;
      default: wake_pins_out.usb_event = 1'b0;
    endcase
  end
endmodule

// ==== bench/tb.sv ====
// self-checking bench for the power, sleep and reset controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, srst_in, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, rst_pin, rst_en;
  logic sleep, baud, wflag, hot;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, rsp;
  logic [7:0] gate, rd;
  logic [3:0] fire;
  psr_pkg::wake_pins_type pins;
  psr_pkg::pin_modes_type modes;
  int n_mismatch, tests_run, n;

  power_sleep_reset_control #(.WDOG_DIVIDE(16)) u_power_sleep_reset_control (
    .clk_in(clk_in), .srst_in(srst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .wake_pins_in(pins),
    .pin_modes_in(modes), .reset_pin_in(rst_pin), .reset_pin_function_enable_in(rst_en),
    .clock_gate_out(gate), .sleep_out(sleep), .serial1_baud_double_out(baud),
    .watchdog_overflow_flag_out(wflag), .hot_reset_out(hot)
  );

  wake_source_model u_wake_source_model (.fire_in(fire), .wake_pins_out(pins));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic timed_out();
    n_mismatch++;
    $display("ERROR t=%0t wait ran out", $time);
    finish_test();
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    int k;
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    rsp = bresp;
    bready <= 1'b0;
    if (k == 40) timed_out();
    @(posedge clk_in);
  endtask

  task automatic rdr(input logic [7:0] idx);
    int k;
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk_in);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rd = rdata[7:0];
    rsp = rresp;
    rready <= 1'b0;
    if (k == 40) timed_out();
    @(posedge clk_in);
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    rdr(idx);
    check(rd, exp);
  endtask

  task automatic unlock();
    // any key write first closes a window still open from an earlier unlock
    wr(psr_pkg::IDX_UNLOCK_KEY, 8'h00);
    wr(psr_pkg::IDX_UNLOCK_KEY, psr_pkg::KEY_FIRST);
    wr(psr_pkg::IDX_UNLOCK_KEY, psr_pkg::KEY_SECOND);
  endtask

  // which: 0 hot reset pulse, 1 sleep left, 2 overflow flag
  task automatic wait_for(input int which, input int bound);
    logic hit;
    for (n = 0; n < bound; n++) begin
      @(posedge clk_in);
      hit = (which == 0) ? hot : (which == 1) ? !sleep : wflag;
      if (hit === 1'b1) break;
    end
    if (n == bound) timed_out();
  endtask

  // sleep, fire a source that must not wake, then the enabled one
  task automatic sleep_wake(input logic [7:0] en, input logic [3:0] other,
    input logic [3:0] src);
    unlock();
    wr(8'hEB, en);
    wr(8'h87, 8'h02);
    check({7'h00, sleep}, 8'h01);
    fire <= other;
    repeat (10) @(posedge clk_in);
    check({7'h00, sleep}, 8'h01);
    fire <= src;
    repeat (3) @(posedge clk_in);
    check({7'h00, sleep}, 8'h01);
    wait_for(1, 10);
    fire <= 4'h0;
    rchk(8'h87, 8'h10);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    rchk(8'h87, 8'h10);
    rchk(8'hEA, 8'h00);
    rchk(8'hEB, 8'h00);
    rchk(8'hFE, 8'h00);
    rchk(8'hFF, 8'h00);
    rdr(8'h10);
    check({6'h00, rsp}, {6'h00, psr_pkg::RESP_SLVERR});
  endtask

  task automatic t_power();
    wr(8'h87, 8'hFD);
    rchk(8'h87, 8'h9C);
    check({7'h00, baud}, 8'h01);
    wr(8'h87, 8'h00);
    rchk(8'h87, 8'h10);
    check({7'h00, baud}, 8'h00);
  endtask

  task automatic t_lock();
    wr(8'hEB, 8'hFF);
    rchk(8'hEB, 8'h00);
    unlock();
    wr(8'hEB, 8'hA5);
    rchk(8'hEB, 8'hA5);
    unlock();
    wr(8'hEA, 8'hFF);
    rchk(8'hEA, 8'hEF);
    check(gate, 8'hEF);
    unlock();
    repeat (8) @(posedge clk_in);
    wr(8'hEA, 8'h00);
    rchk(8'hEA, 8'h00);
    unlock();
    repeat (24) @(posedge clk_in);
    wr(8'hEB, 8'h00);
    rchk(8'hEB, 8'hA5);
    unlock();
    wr(psr_pkg::IDX_UNLOCK_KEY, 8'h00);
    wr(8'hEB, 8'h00);
    rchk(8'hEB, 8'hA5);
  endtask

  task automatic t_wake();
    for (int b = 0; b < 8; b++) begin
      sleep_wake(8'h01 << b, 4'((b + 1) % 8 + 1), 4'(b + 1));
    end
  endtask

  // alternate pins, rs485 pair, capture mode off and the port3 pin2 edge
  task automatic t_wake_alt();
    modes <= psr_pkg::pin_modes_type'(5'h0F);
    sleep_wake(8'h40, 4'h7, 4'hA);
    sleep_wake(8'h04, 4'h3, 4'hC);
    sleep_wake(8'h01, 4'h1, 4'hB);
    sleep_wake(8'h02, 4'h8, 4'h9);
    modes <= psr_pkg::pin_modes_type'(5'h00);
    sleep_wake(8'h44, 4'h3, 4'hD);
    modes <= psr_pkg::pin_modes_type'(5'h14);
  endtask

  task automatic t_watchdog();
    wr(8'hFE, 8'h5A);
    wr(8'hFF, 8'hFE);
    wait_for(2, 60);
    check({7'h00, n >= 14 && n <= 34}, 8'h01);
    rchk(8'hFF, 8'h00);
    check({7'h00, wflag}, 8'h01);
    wr(8'hFF, 8'h00);
    check({7'h00, wflag}, 8'h00);
    unlock();
    wr(8'hB1, 8'h01);
    wr(8'hFF, 8'hFF);
    wait_for(0, 40);
    rchk(8'h87, 8'h20);
    rchk(8'hFE, 8'h5A);
  endtask

  task automatic t_sw_reset();
    unlock();
    wr(8'hB1, 8'h10);
    rchk(8'h87, 8'h20);
    unlock();
    wr(8'hB1, 8'h10);
    rchk(8'h87, 8'h00);
    rchk(8'hFE, 8'h5A);
  endtask

  task automatic t_ext_reset();
    rst_pin <= 1'b1;
    repeat (24) @(posedge clk_in);
    rst_pin <= 1'b0;
    rchk(8'h87, 8'h00);
    rst_en <= 1'b1;
    rst_pin <= 1'b1;
    wait_for(0, 40);
    check({7'h00, n >= 14}, 8'h01);
    rst_pin <= 1'b0;
    rchk(8'h87, 8'h30);
    rchk(8'hFE, 8'h5A);
  endtask

  task automatic t_power_on();
    srst_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    rchk(8'hFE, 8'h00);
    rchk(8'h87, 8'h10);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    srst_in = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, rst_pin, rst_en} = 7'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0000_0000;
    fire = 4'h0;
    modes = psr_pkg::pin_modes_type'(5'h14);
    n_mismatch = 0;
    tests_run = 0;
    repeat (10) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    t_reset_values();
    t_power();
    t_lock();
    t_wake();
    t_wake_alt();
    t_watchdog();
    t_sw_reset();
    t_ext_reset();
    t_power_on();
    finish_test();
  end
endmodule
